// ### rtl/accs_clock_select.sv
// analog column clock selector: select register, source muxes, dividers
`timescale 1ns/10ps
`default_nettype none
module accs_clock_select #(
  parameter int NUM_COLUMNS = 4,
  parameter bit REDUCED_TWO_COLUMN = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [accs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [accs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [accs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic variable_clock_one,
  input wire logic variable_clock_two,
  input wire logic analog_clock_zero,
  input wire logic analog_clock_one,
  output logic [accs_pkg::MAX_COLUMNS-1:0] col_clk
);
  import accs_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // only the documented column counts exist; the reduced variant is two-column
  if (!(NUM_COLUMNS == 1 || NUM_COLUMNS == 2 || NUM_COLUMNS == 4)) begin : g_bad_cols
    $error("NUM_COLUMNS must be 1, 2 or 4");
  end
  if (REDUCED_TWO_COLUMN && NUM_COLUMNS != 2) begin : g_bad_reduced
    $error("REDUCED_TWO_COLUMN needs NUM_COLUMNS of 2");
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // mask of implemented select bits for the variant
  function automatic logic [7:0] impl_mask(input int cols);
    logic [7:0] m;
    m = 8'h00;
    if (cols == 4) begin
      m = 8'hff;
    end else if (cols == 2) begin
      m = 8'h0f;
    end else begin
      m = 8'h0c;
    end
    return m;
  endfunction : impl_mask

  // pick one sampled source level from a select code
  function automatic logic pick_source(input logic [1:0] sel, input logic [3:0] srcs);
    logic s;
    s = 1'b0;
    case (sel)
      SRC_VARIABLE_ONE: s = srcs[0];
      SRC_VARIABLE_TWO: s = srcs[1];
      SRC_ANALOG_ZERO: s = srcs[2];
      SRC_ANALOG_ONE: s = srcs[3];
      default: s = 1'b0;
    endcase
    return s;
  endfunction : pick_source

  // half period in source edges for a divider configuration field
  function automatic logic [HALF_CNT_W-1:0] cfg_half(input logic [1:0] field);
    logic [HALF_CNT_W-1:0] h;
    h = 4'h1 << field; // divide ratio 2, 4, 8, 16
    return h;
  endfunction : cfg_half

  localparam logic [7:0] SEL_MASK = impl_mask(NUM_COLUMNS);
  // the divider configuration only exists on the reduced variant
  localparam logic [7:0] DIV_MASK = REDUCED_TWO_COLUMN ? 8'h0f : 8'h00;

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [MAX_COLUMNS-1:0] col_clk_int;

  // writes keep only implemented bits, so reserved bits stay zero
  always_comb begin
    sel_next = sel_reg;
    div_next = div_reg;
    if (reg_write && reg_addr == CLK_SEL_OFFSET) begin
      sel_next = reg_wdata & SEL_MASK;
    end
    if (reg_write && reg_addr == DIV_CFG_OFFSET) begin
      div_next = reg_wdata & DIV_MASK;
    end
  end

  // read data appear in the cycle after the strobe and only then
  always_comb begin
    rdata_next = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        CLK_SEL_OFFSET: rdata_next = sel_reg & SEL_MASK;
        DIV_CFG_OFFSET: rdata_next = div_reg & DIV_MASK;
        COL_STATUS_OFFSET: rdata_next = {4'h0, col_clk_int};
        default: rdata_next = 8'h00; // unmapped reads answer zero
      endcase
    end
  end

  // register stage for the register file and read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg <= CLK_SEL_RESET;
      div_reg <= DIV_CFG_RESET;
      rdata_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      div_reg <= div_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------------
  // per-column source mux and divider
  // ------------------------------------------------------------------
  logic [3:0] src_bus;
  assign src_bus = {analog_clock_one, analog_clock_zero, variable_clock_two, variable_clock_one};

  // sources are sampled at clk, so each must run well below half of 50 MHz
  for (genvar c = 0; c < MAX_COLUMNS; c++) begin : g_col
    logic src_sel;
    logic [HALF_CNT_W-1:0] half;
    logic present;
    assign present = SEL_MASK[2*c];
    assign src_sel = present ? pick_source(sel_reg[2*c +: SEL_W], src_bus) : 1'b0;
    // fixed quarter rate except on the reduced variant
    assign half = REDUCED_TWO_COLUMN ? cfg_half(div_reg[2*c +: SEL_W])
                                     : FIXED_HALF_EDGES;
    accs_col_divider u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_level(src_sel),
      .half_edges(half),
      .col_clk(col_clk_int[c])
    );
  end

  // absent columns are held low
  assign col_clk = col_clk_int;

endmodule : accs_clock_select
`default_nettype wire

// ### rtl/accs_col_divider.sv
// divides one sampled source clock level into a column clock
`timescale 1ns/10ps
`default_nettype none
module accs_col_divider (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic src_level,
  input wire logic [accs_pkg::HALF_CNT_W-1:0] half_edges,
  output logic col_clk
);
  import accs_pkg::*;

  logic src_prev_reg;
  logic src_prev_next;
  logic [HALF_CNT_W-1:0] cnt_reg;
  logic [HALF_CNT_W-1:0] cnt_next;
  logic out_reg;
  logic out_next;
  logic rise;

  // ------------------------------------------------------------------
  // edge counting
  // ------------------------------------------------------------------
  // count rising edges of the source; toggle the output every half period
  always_comb begin
    src_prev_next = src_level;
    rise = src_level & ~src_prev_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (rise) begin
      // >= guards against a half period shrinking below the running count
      if (cnt_reg + 4'h1 >= half_edges) begin
        cnt_next = '0;
        out_next = ~out_reg;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_prev_reg <= 1'b0;
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign col_clk = out_reg;

endmodule : accs_col_divider
`default_nettype wire

// ### rtl/accs_pkg.sv
// constants shared by the analog column clock selector
package accs_pkg;

  // ------------------------------------------------------------------
  // register bus shape
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] CLK_SEL_OFFSET = 8'h60;
  localparam logic [7:0] DIV_CFG_OFFSET = 8'h63;
  localparam logic [7:0] COL_STATUS_OFFSET = 8'h64;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] DIV_CFG_RESET = 8'h00;

  // ------------------------------------------------------------------
  // field layout: column n owns bits [2n+1:2n] in both registers
  // ------------------------------------------------------------------
  localparam int SEL_W = 2;
  localparam int COL0_LSB = 0;
  localparam int COL1_LSB = 2;
  localparam int COL2_LSB = 4;
  localparam int COL3_LSB = 6;
  localparam int MAX_COLUMNS = 4;

  // ------------------------------------------------------------------
  // source select encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] SRC_VARIABLE_ONE = 2'h0;
  localparam logic [1:0] SRC_VARIABLE_TWO = 2'h1;
  localparam logic [1:0] SRC_ANALOG_ZERO = 2'h2;
  localparam logic [1:0] SRC_ANALOG_ONE = 2'h3;

  // ------------------------------------------------------------------
  // division: column clock toggles every HALF source rising edges
  // ------------------------------------------------------------------
  localparam int FIXED_DIVIDE = 4;
  localparam logic [3:0] FIXED_HALF_EDGES = 4'(FIXED_DIVIDE / 2);
  localparam int HALF_CNT_W = 4;

endpackage : accs_pkg

// ### verif/accs_clock_select_sva.sv
// assertion checker for the analog column clock selector
`timescale 1ns/10ps
`default_nettype none
module accs_clock_select_sva #(
  parameter int NUM_COLUMNS = 4,
  parameter bit REDUCED_TWO_COLUMN = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [accs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [accs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [accs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic variable_clock_one,
  input wire logic variable_clock_two,
  input wire logic analog_clock_zero,
  input wire logic analog_clock_one,
  input wire logic [accs_pkg::MAX_COLUMNS-1:0] col_clk
);
  import accs_pkg::*;
  // ----------------------------------------------------------------
  // shadow of the select register and column 0 source edge count
  // ----------------------------------------------------------------
  logic [7:0] sel_q;
  logic [3:0] srcs;
  logic lvl_d;
  logic col_d;
  logic [2:0] rise_cnt;
  wire logic [7:0] smask = (NUM_COLUMNS == 4) ? 8'hff : (NUM_COLUMNS == 2) ? 8'h0f : 8'h0c;
  wire logic [3:0] cmask = (NUM_COLUMNS == 4) ? 4'hf : (NUM_COLUMNS == 2) ? 4'h3 : 4'h2;
  wire logic rise0 = srcs[sel_q[1:0]] & ~lvl_d;
  assign srcs = {analog_clock_one, analog_clock_zero, variable_clock_two, variable_clock_one};
  // count restarts on each column toggle, so outside the reduced variant it must read two at every toggle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_q <= 8'h00;
      lvl_d <= 1'b0;
      col_d <= 1'b0;
      rise_cnt <= 3'h0;
    end else begin
      if (reg_write && reg_addr == CLK_SEL_OFFSET) sel_q <= reg_wdata & smask;
      lvl_d <= srcs[sel_q[1:0]];
      col_d <= col_clk[0];
      rise_cnt <= (col_clk[0] != col_d) ? {2'h0, rise0} : rise_cnt + {2'h0, rise0};
    end
  end
  sequence sel_read;
    reg_read && reg_addr == CLK_SEL_OFFSET;
  endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_sel_readback: assert property (sel_read |=> reg_rdata == sel_q)
    else $error("select readback differs from written value");
  chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst |=> col_clk == 4'h0)
    else $error("column clocks not cleared by reset");
  chk_div_toggle: assert property (!REDUCED_TWO_COLUMN && $changed(col_clk[0]) |-> rise_cnt == 3'h2)
    else $error("column 0 toggled without two source rises");
  chk_div_late: assert property (!REDUCED_TWO_COLUMN |-> rise_cnt <= 3'h2)
    else $error("column 0 missed its toggle");
  chk_absent_cols: assert property ((col_clk & ~cmask) == 4'h0)
    else $error("absent column clock moved");
endmodule : accs_clock_select_sva
bind accs_clock_select accs_clock_select_sva #(.NUM_COLUMNS(NUM_COLUMNS),
  .REDUCED_TWO_COLUMN(REDUCED_TWO_COLUMN)) u_sva (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .variable_clock_one(variable_clock_one),
  .variable_clock_two(variable_clock_two), .analog_clock_zero(analog_clock_zero),
  .analog_clock_one(analog_clock_one), .col_clk(col_clk));
`default_nettype wire

// ### verif/accs_clock_select_tb.sv
// self-checking bench for the analog column clock selector
`timescale 1ns/10ps
`default_nettype none
module accs_clock_select_tb;
  import accs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] src = 4'h0;
  logic [3:0] col_clk;
  logic [3:0] prv = 4'h0;
  logic [7:0] tog [4];
  logic [7:0] rdata_r;
  logic [3:0] col_clk_r;
  logic [3:0] prv_r = 4'h0;
  logic [7:0] tog_r [4];
  int miscompares = 0;
  int checks = 0;
  always #10 clk = ~clk;
  accs_clock_select DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .variable_clock_one(src[0]), .variable_clock_two(src[1]), .analog_clock_zero(src[2]),
    .analog_clock_one(src[3]), .col_clk(col_clk));
  // reduced two-column variant on the same bus; its software keeps reserved bits zero
  accs_clock_select #(.NUM_COLUMNS(2), .REDUCED_TWO_COLUMN(1'b1)) DUT_R (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata & 8'h0f),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata_r),
    .variable_clock_one(src[0]), .variable_clock_two(src[1]), .analog_clock_zero(src[2]),
    .analog_clock_one(src[3]), .col_clk(col_clk_r));
  // ----------------------------------------------------------------
  // edge counting and bus tasks
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    for (int n = 0; n < 4; n++) if (col_clk[n] !== prv[n]) tog[n] = tog[n] + 8'h01;
    prv = col_clk;
    for (int n = 0; n < 4; n++) if (col_clk_r[n] !== prv_r[n]) tog_r[n] = tog_r[n] + 8'h01;
    prv_r = col_clk_r;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  // read data only stand one cycle, so sample just after the answering edge
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp,
                        input logic [7:0] exp_r);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(what, reg_rdata, exp);
    check({what, " reduced"}, rdata_r, exp_r);
  endtask : rd_chk
  // 32 source rises: the matching column toggles 16 times, the rest stay put
  task automatic run_src(input int s);
    for (int n = 0; n < 4; n++) tog[n] = 8'h00;
    for (int n = 0; n < 4; n++) tog_r[n] = 8'h00;
    repeat (32) begin
      src[s] <= 1'b1;
      repeat (2) @(posedge clk);
      src[s] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    for (int n = 0; n < 4; n++) check("column toggles", tog[n], (n == s) ? 8'h10 : 8'h00);
    // reduced: column 0 runs at /4, column 1 at /2, absent columns never move
    for (int n = 0; n < 4; n++) begin
      check("reduced toggles", tog_r[n], (n != s) ? 8'h00 : (s == 0) ? 8'h10 : (s == 1) ? 8'h20 : 8'h00);
    end
    $display("source %0d test done", s);
  endtask : run_src
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // test sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("select at reset", CLK_SEL_OFFSET, 8'h00, 8'h00);
    wr(CLK_SEL_OFFSET, 8'h55);
    rd_chk("select 55", CLK_SEL_OFFSET, 8'h55, 8'h05);
    wr(CLK_SEL_OFFSET, 8'haa);
    rd_chk("select aa", CLK_SEL_OFFSET, 8'haa, 8'h0a);
    wr(8'h61, 8'hff);
    rd_chk("select after stray write", CLK_SEL_OFFSET, 8'haa, 8'h0a);
    rd_chk("unmapped read", 8'h61, 8'h00, 8'h00);
    rd_chk("divider absent", DIV_CFG_OFFSET, 8'h00, 8'h00);
    wr(DIV_CFG_OFFSET, 8'hf1);
    rd_chk("divider config", DIV_CFG_OFFSET, 8'h00, 8'h01);
    $display("register test done");
    wr(CLK_SEL_OFFSET, 8'he4);
    for (int s = 0; s < 4; s++) run_src(s);
    // two more rises leave column 0 high in both variants
    repeat (2) begin
      src[0] <= 1'b1;
      repeat (2) @(posedge clk);
      src[0] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rd_chk("column status", COL_STATUS_OFFSET, 8'h01, 8'h01);
    wr(CLK_SEL_OFFSET, 8'hff);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("select after second reset", CLK_SEL_OFFSET, 8'h00, 8'h00);
    rd_chk("divider after second reset", DIV_CFG_OFFSET, 8'h00, 8'h00);
    $display("reset test done");
    wrap_up;
  end
  // whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule : accs_clock_select_tb
`default_nettype wire
